// *** core/scps_top.v ***
// apb register file and both channels of the clock pin select block
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "scps_defines.vh"
module scps_top #(
  parameter ADDR_W = 8 // byte address width seen by the slave
) (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // shared oscillator output of the crystal pair
  input wire osc_clk,
  // channel a pins and clock sources
  input wire alt_clock_pin_a,
  input wire transmit_clock_pin_in_a,
  output wire transmit_clock_pin_out_a,
  output wire transmit_clock_pin_oe_a,
  input wire receive_clock_pin_a,
  input wire baud_clk_a,
  input wire digital_phase_locked_loop_clk_a,
  input wire tx_slot_active_a,
  // channel a selected clocks
  output wire tx_clk_a,
  output wire rx_clk_a,
  output wire baud_in_a,
  output wire tx_strobe_a,
  // channel b pins and clock sources
  input wire alt_clock_pin_b,
  input wire transmit_clock_pin_in_b,
  output wire transmit_clock_pin_out_b,
  output wire transmit_clock_pin_oe_b,
  input wire receive_clock_pin_b,
  input wire baud_clk_b,
  input wire digital_phase_locked_loop_clk_b,
  input wire tx_slot_active_b,
  // channel b selected clocks
  output wire tx_clk_b,
  output wire rx_clk_b,
  output wire baud_in_b,
  output wire tx_strobe_b
);
  // per channel configuration, one register each
  reg [`SCPS_CFG_W-1:0] cfg_a_ff;
  reg [`SCPS_CFG_W-1:0] cfg_b_ff;
  // status words from the channels
  wire [`SCPS_ST_W-1:0] stat_a;
  wire [`SCPS_ST_W-1:0] stat_b;
  // apb phase decodes
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable && pready;
  wire wr_done = access_ph && pwrite;
  // address decodes
  wire hit_cfg_a = (paddr == `SCPS_CFG_A_OFS);
  wire hit_cfg_b = (paddr == `SCPS_CFG_B_OFS);
  wire hit_st_a = (paddr == `SCPS_STAT_A_OFS);
  wire hit_st_b = (paddr == `SCPS_STAT_B_OFS);
  wire hit_any = hit_cfg_a || hit_cfg_b || hit_st_a || hit_st_b;
  // next values of the answer flops
  reg [31:0] nxt_prdata;
  reg nxt_pready;
  reg nxt_pslverr;

  // read mux: data is captured in setup so prdata comes from a flop
  always @* begin
    nxt_prdata = 32'h0000_0000;
    if (hit_cfg_a) begin
      nxt_prdata = {26'h0, cfg_a_ff};
    end else if (hit_cfg_b) begin
      nxt_prdata = {26'h0, cfg_b_ff};
    end else if (hit_st_a) begin
      nxt_prdata = {25'h0, stat_a};
    end else if (hit_st_b) begin
      nxt_prdata = {25'h0, stat_b};
    end
  end

  // answer timing: pready rises in the first access cycle, one wait-free beat
  always @* begin
    nxt_pready = setup_ph;
    nxt_pslverr = setup_ph && (!hit_any || (pwrite && (hit_st_a || hit_st_b)));
  end

  // answer flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
      // hold read data over the access so the master sees it stable
      if (setup_ph) begin
        prdata <= (pwrite) ? 32'h0000_0000 : nxt_prdata;
      end else if (access_ph) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // configuration writes land only on the completing access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_ff <= `SCPS_CFG_RST;
      cfg_b_ff <= `SCPS_CFG_RST;
    end else begin
      if (wr_done && hit_cfg_a) begin
        cfg_a_ff <= pwdata[`SCPS_CFG_W-1:0];
      end
      if (wr_done && hit_cfg_b) begin
        cfg_b_ff <= pwdata[`SCPS_CFG_W-1:0];
      end
    end
  end

  // channel a owns the crystal pin pair
  scps_channel #(
    .HAS_XTAL(1)
  ) u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .clock_mode(cfg_a_ff[`SCPS_CFG_MODE_MSB:`SCPS_CFG_MODE_LSB]),
    .tx_clock_source_bit(cfg_a_ff[`SCPS_CFG_SRC_BIT]),
    .tx_clock_direction_bit(cfg_a_ff[`SCPS_CFG_DIR_BIT]),
    .auto_start(cfg_a_ff[`SCPS_CFG_AUTO_BIT]),
    .alt_clock_pin(alt_clock_pin_a),
    .transmit_clock_pin_in(transmit_clock_pin_in_a),
    .receive_clock_pin(receive_clock_pin_a),
    .baud_clk(baud_clk_a),
    .digital_phase_locked_loop_clk(digital_phase_locked_loop_clk_a),
    .osc_clk(osc_clk),
    .tx_slot_active(tx_slot_active_a),
    .transmit_clock_pin_out(transmit_clock_pin_out_a),
    .transmit_clock_pin_oe(transmit_clock_pin_oe_a),
    .tx_clk_ff(tx_clk_a),
    .rx_clk_ff(rx_clk_a),
    .baud_in_ff(baud_in_a),
    .tx_strobe_ff(tx_strobe_a),
    .status_ff(stat_a)
  );

  // channel b borrows the oscillator; its alt pin never becomes a crystal
  scps_channel #(
    .HAS_XTAL(0)
  ) u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .clock_mode(cfg_b_ff[`SCPS_CFG_MODE_MSB:`SCPS_CFG_MODE_LSB]),
    .tx_clock_source_bit(cfg_b_ff[`SCPS_CFG_SRC_BIT]),
    .tx_clock_direction_bit(cfg_b_ff[`SCPS_CFG_DIR_BIT]),
    .auto_start(cfg_b_ff[`SCPS_CFG_AUTO_BIT]),
    .alt_clock_pin(alt_clock_pin_b),
    .transmit_clock_pin_in(transmit_clock_pin_in_b),
    .receive_clock_pin(receive_clock_pin_b),
    .baud_clk(baud_clk_b),
    .digital_phase_locked_loop_clk(digital_phase_locked_loop_clk_b),
    .osc_clk(osc_clk),
    .tx_slot_active(tx_slot_active_b),
    .transmit_clock_pin_out(transmit_clock_pin_out_b),
    .transmit_clock_pin_oe(transmit_clock_pin_oe_b),
    .tx_clk_ff(tx_clk_b),
    .rx_clk_ff(rx_clk_b),
    .baud_in_ff(baud_in_b),
    .tx_strobe_ff(tx_strobe_b),
    .status_ff(stat_b)
  );
endmodule

// *** core/scps_defines.vh ***
// constants for the serial channel clock pin select block
`ifndef SCPS_DEFINES_VH
`define SCPS_DEFINES_VH
// register byte offsets
`define SCPS_CFG_A_OFS 8'h00
`define SCPS_CFG_B_OFS 8'h04
`define SCPS_STAT_A_OFS 8'h08
`define SCPS_STAT_B_OFS 8'h0C
// configuration field positions
`define SCPS_CFG_MODE_LSB 0
`define SCPS_CFG_MODE_MSB 2
`define SCPS_CFG_SRC_BIT 3
`define SCPS_CFG_DIR_BIT 4
`define SCPS_CFG_AUTO_BIT 5
`define SCPS_CFG_W 6
`define SCPS_CFG_RST 6'h00
// status field positions
`define SCPS_ST_ALT_BIT 0
`define SCPS_ST_CARR_BIT 1
`define SCPS_ST_RXEN_BIT 2
`define SCPS_ST_RXSTB_BIT 3
`define SCPS_ST_FSYNC_BIT 4
`define SCPS_ST_XTAL_BIT 5
`define SCPS_ST_TXOE_BIT 6
`define SCPS_ST_W 7
// clock modes
`define SCPS_MODE_0 3'h0
`define SCPS_MODE_1 3'h1
`define SCPS_MODE_2 3'h2
`define SCPS_MODE_3 3'h3
`define SCPS_MODE_4 3'h4
`define SCPS_MODE_5 3'h5
`define SCPS_MODE_6 3'h6
`define SCPS_MODE_7 3'h7
`endif

// *** core/scps_channel.v ***
// one channel of clock pin role selection
`timescale 1ns/1ps
`include "scps_defines.vh"
module scps_channel #(
  parameter HAS_XTAL = 1 // only channel a owns the crystal pin pair
) (
  input wire pclk,
  input wire presetn,
  input wire [2:0] clock_mode,
  input wire tx_clock_source_bit,
  input wire tx_clock_direction_bit,
  input wire auto_start,
  input wire alt_clock_pin,
  input wire transmit_clock_pin_in,
  input wire receive_clock_pin,
  input wire baud_clk,
  input wire digital_phase_locked_loop_clk,
  input wire osc_clk,
  input wire tx_slot_active,
  output reg transmit_clock_pin_out,
  output reg transmit_clock_pin_oe,
  output reg tx_clk_ff,
  output reg rx_clk_ff,
  output reg baud_in_ff,
  output reg tx_strobe_ff,
  output reg [`SCPS_ST_W-1:0] status_ff
);
  // mode decodes
  wire m1 = (clock_mode == `SCPS_MODE_1);
  wire m5 = (clock_mode == `SCPS_MODE_5);
  wire m_x = (clock_mode == `SCPS_MODE_4) || (clock_mode == `SCPS_MODE_6) ||
             (clock_mode == `SCPS_MODE_7);
  wire xtal = m_x && (HAS_XTAL != 0);
  wire m026 = (clock_mode == `SCPS_MODE_0) || (clock_mode == `SCPS_MODE_2) ||
              (clock_mode == `SCPS_MODE_6);
  reg nxt_out, nxt_oe, nxt_tx, nxt_rx, nxt_baud, nxt_tstb;
  reg [`SCPS_ST_W-1:0] nxt_st;
  // pin role selection
  always @* begin
    nxt_oe = tx_clock_direction_bit;
    nxt_out = 1'b0;
    nxt_tx = 1'b0;
    nxt_tstb = 1'b0;
    nxt_st = {`SCPS_ST_W{1'b0}};
    // alt pin: crystal wins, then strobe, frame sync, auto start, carrier detect
    nxt_st[`SCPS_ST_XTAL_BIT] = xtal;
    if (xtal) begin
      nxt_st[`SCPS_ST_ALT_BIT] = 1'b0;
    end else begin
      nxt_st[`SCPS_ST_ALT_BIT] = alt_clock_pin;
      if (m1) begin
        nxt_st[`SCPS_ST_RXSTB_BIT] = alt_clock_pin;
      end else if (m5) begin
        nxt_st[`SCPS_ST_FSYNC_BIT] = alt_clock_pin;
      end else if (auto_start) begin
        nxt_st[`SCPS_ST_RXEN_BIT] = alt_clock_pin;
      end else begin
        nxt_st[`SCPS_ST_CARR_BIT] = alt_clock_pin;
      end
    end
    nxt_st[`SCPS_ST_TXOE_BIT] = tx_clock_direction_bit;
    // receive clock pin role
    case (clock_mode)
      `SCPS_MODE_0: begin
        nxt_rx = receive_clock_pin;
        nxt_baud = 1'b0;
      end
      `SCPS_MODE_1, `SCPS_MODE_5: begin
        nxt_rx = receive_clock_pin;
        nxt_baud = 1'b0;
      end
      `SCPS_MODE_2, `SCPS_MODE_3: begin
        nxt_rx = digital_phase_locked_loop_clk;
        nxt_baud = receive_clock_pin;
      end
      default: begin
        // crystal modes: pin carries no logic level
        nxt_rx = digital_phase_locked_loop_clk;
        nxt_baud = osc_clk;
      end
    endcase
    // transmit side
    if (tx_clock_source_bit) begin
      // source bit overrides the pin role; generator output only in modes 2 and 6
      nxt_tx = baud_clk;
      if (tx_clock_direction_bit && (clock_mode == `SCPS_MODE_2 ||
          clock_mode == `SCPS_MODE_6)) begin
        nxt_out = baud_clk;
      end
    end else if (!tx_clock_direction_bit) begin
      if (m026) begin
        nxt_tx = transmit_clock_pin_in;
      end else if (m1) begin
        nxt_tx = receive_clock_pin;
        nxt_tstb = transmit_clock_pin_in;
      end else if (m5) begin
        nxt_tx = receive_clock_pin;
      end else if (clock_mode == `SCPS_MODE_4) begin
        nxt_tx = osc_clk;
      end else begin
        nxt_tx = digital_phase_locked_loop_clk;
      end
    end else begin
      case (clock_mode)
        `SCPS_MODE_3, `SCPS_MODE_7: begin
          nxt_tx = digital_phase_locked_loop_clk;
          nxt_out = digital_phase_locked_loop_clk;
        end
        `SCPS_MODE_4: begin
          nxt_tx = osc_clk;
          nxt_out = osc_clk;
        end
        `SCPS_MODE_5: begin
          nxt_tx = receive_clock_pin;
          nxt_out = tx_slot_active;
        end
        `SCPS_MODE_1: begin
          nxt_tx = receive_clock_pin;
        end
        default: begin
          // modes 0, 2, 6 with source clear drive nothing useful
          nxt_tx = 1'b0;
        end
      endcase
    end
  end
  // register every result so the top sees flops only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe <= 1'b0;
      tx_clk_ff <= 1'b0;
      rx_clk_ff <= 1'b0;
      baud_in_ff <= 1'b0;
      tx_strobe_ff <= 1'b0;
      status_ff <= {`SCPS_ST_W{1'b0}};
    end else begin
      transmit_clock_pin_out <= nxt_out;
      transmit_clock_pin_oe <= nxt_oe;
      tx_clk_ff <= nxt_tx;
      rx_clk_ff <= nxt_rx;
      baud_in_ff <= nxt_baud;
      tx_strobe_ff <= nxt_tstb;
      status_ff <= nxt_st;
    end
  end
endmodule

// *** tb/scps_chk.sv ***
// assertions on the clock pin select top ports, channel a
`timescale 1ns/1ps
module scps_chk #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire osc_clk,
  input wire transmit_clock_pin_in_a,
  input wire receive_clock_pin_a,
  input wire baud_clk_a,
  input wire digital_phase_locked_loop_clk_a,
  input wire tx_slot_active_a,
  input wire transmit_clock_pin_out_a,
  input wire transmit_clock_pin_oe_a,
  input wire tx_clk_a,
  input wire rx_clk_a,
  input wire baud_in_a,
  input wire tx_strobe_a
);
  reg [5:0] cfg_ff; // shadow of channel a config
  reg [5:0] pc_ff; // one edge late, lines up with the output flop
  reg [1:0] up_ff; // skips edges right after reset release
  // track completed writes, since config is not visible at the ports
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 6'h00;
      pc_ff <= 6'h00;
      up_ff <= 2'h0;
    end else begin
      pc_ff <= cfg_ff;
      if (!up_ff[1]) begin
        up_ff <= up_ff + 2'h1;
      end
      if (psel && penable && pready && pwrite && paddr == 'h0) begin
        cfg_ff <= pwdata[5:0];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !up_ff[1]);
  wire [2:0] md = pc_ff[2:0]; // mode in force
  wire [1:0] dx = pc_ff[4:3]; // direction and source bits
  sequence apb_setup;
    psel && !penable;
  endsequence
  a_apb_ready: assert property (apb_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_tx_dir_oe: assert property (transmit_clock_pin_oe_a == pc_ff[4])
    else $error("transmit pin direction wrong");
  a_tx_in_clk: assert property (dx == 2'h0 && md inside {3'h0, 3'h2, 3'h6}
    |-> tx_clk_a == $past(transmit_clock_pin_in_a)) else $error("tx clock not pin");
  a_tx_strobe: assert property (dx == 2'h0 && md == 3'h1
    |-> tx_strobe_a == $past(transmit_clock_pin_in_a)) else $error("strobe not pin");
  a_tx_src_baud: assert property (pc_ff[3] |-> tx_clk_a == $past(baud_clk_a))
    else $error("tx clock not generator");
  a_out_digital_phase_locked_loop: assert property (dx == 2'h2 && md inside {3'h3, 3'h7}
    |-> transmit_clock_pin_out_a == $past(digital_phase_locked_loop_clk_a)) else $error("out not digital_phase_locked_loop");
  a_out_slot: assert property (dx == 2'h2 && md == 3'h5
    |-> transmit_clock_pin_out_a == $past(tx_slot_active_a)) else $error("out not slot");
  a_rx_pin: assert property (md inside {3'h0, 3'h1, 3'h5}
    |-> rx_clk_a == $past(receive_clock_pin_a)) else $error("rx clock not pin");
  a_baud_pin: assert property (md inside {3'h2, 3'h3}
    |-> baud_in_a == $past(receive_clock_pin_a)) else $error("generator input wrong");
  a_baud_xtal: assert property (md inside {3'h4, 3'h6, 3'h7}
    |-> baud_in_a == $past(osc_clk)) else $error("crystal input wrong");
endmodule
bind scps_top scps_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .osc_clk, .transmit_clock_pin_in_a,
  .receive_clock_pin_a, .baud_clk_a, .digital_phase_locked_loop_clk_a, .tx_slot_active_a,
  .transmit_clock_pin_out_a, .transmit_clock_pin_oe_a, .tx_clk_a, .rx_clk_a,
  .baud_in_a, .tx_strobe_a);

// *** tb/scps_line_model.sv ***
// line side model: free running far end clocks and a held alt level
`timescale 1ns/1ps
module scps_line_model #(
  parameter [3:0] SH = 4'h0
) (
  input wire pclk,
  input wire alt_lvl,
  output logic alt_clock_pin = 1'b0,
  output logic transmit_clock_pin_in = 1'b0,
  output logic receive_clock_pin = 1'b0
);
  logic [3:0] div_ff = 4'h0; // divider, SH skews the channels apart
  // pins change only right after the local edge, like a real far end
  always @(posedge pclk) begin
    div_ff <= div_ff + 4'h1 + SH;
    receive_clock_pin <= div_ff[1];
    transmit_clock_pin_in <= div_ff[2] ^ div_ff[0];
    alt_clock_pin <= alt_lvl;
  end
endmodule

// *** tb/tb.sv ***
// testbench for the clock pin select block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic alt_a = 1'b1, alt_b = 1'b1; // levels the line holds on alt pins
  logic [7:0] cnt_ff = 8'h00; // feeds the internal generator levels
  logic [31:0] rd; // last read data
  logic er; // last error flag
  int error_cnt = 0, comparisons = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire osc_clk = cnt_ff[2];
  wire baud_clk_a = cnt_ff[0], digital_phase_locked_loop_clk_a = cnt_ff[1], tx_slot_active_a = cnt_ff[3];
  wire baud_clk_b = cnt_ff[1], digital_phase_locked_loop_clk_b = cnt_ff[0], tx_slot_active_b = cnt_ff[4];
  wire alt_clock_pin_a, transmit_clock_pin_in_a, receive_clock_pin_a;
  wire alt_clock_pin_b, transmit_clock_pin_in_b, receive_clock_pin_b;
  wire transmit_clock_pin_out_a, transmit_clock_pin_oe_a, tx_clk_a, rx_clk_a;
  wire transmit_clock_pin_out_b, transmit_clock_pin_oe_b, tx_clk_b, rx_clk_b;
  wire baud_in_a, tx_strobe_a, baud_in_b, tx_strobe_b;
  logic [5:0] pb_q = 6'h00; // channel b osc, slot, digital_phase_locked_loop, baud, tx pin, rx pin one edge back
  always #12.5 pclk = ~pclk;
  // generator levels move right after each edge
  always @(posedge pclk) begin
    cnt_ff <= cnt_ff + 8'h01;
  end
  // channel b far side levels as the design's flops took them at the last edge
  always @(posedge pclk) begin
    pb_q <= {osc_clk, tx_slot_active_b, digital_phase_locked_loop_clk_b, baud_clk_b, transmit_clock_pin_in_b,
      receive_clock_pin_b};
  end
  scps_line_model #(.SH(4'h0)) u_line_a (.pclk, .alt_lvl(alt_a), .alt_clock_pin(alt_clock_pin_a),
    .transmit_clock_pin_in(transmit_clock_pin_in_a), .receive_clock_pin(receive_clock_pin_a));
  scps_line_model #(.SH(4'h2)) u_line_b (.pclk, .alt_lvl(alt_b), .alt_clock_pin(alt_clock_pin_b),
    .transmit_clock_pin_in(transmit_clock_pin_in_b), .receive_clock_pin(receive_clock_pin_b));
  scps_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_clk, .alt_clock_pin_a, .transmit_clock_pin_in_a,
    .transmit_clock_pin_out_a, .transmit_clock_pin_oe_a, .receive_clock_pin_a, .baud_clk_a,
    .digital_phase_locked_loop_clk_a, .tx_slot_active_a, .tx_clk_a, .rx_clk_a, .baud_in_a, .tx_strobe_a,
    .alt_clock_pin_b, .transmit_clock_pin_in_b, .transmit_clock_pin_out_b,
    .transmit_clock_pin_oe_b, .receive_clock_pin_b, .baud_clk_b, .digital_phase_locked_loop_clk_b,
    .tx_slot_active_b, .tx_clk_b, .rx_clk_b, .baud_in_b, .tx_strobe_b);
  // one apb transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no limit here: the watchdog ends a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset values, field widths, independence and refused accesses
  task automatic t_regs();
    apb(1'b0, 8'h04, 32'h0);
    `CHK({er, rd}, 33'h0)
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000003F)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 8'h08, 32'h1);
    `CHK(er, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, 8'h00, 32'h0);
    $display("t_regs done");
  endtask
  // set a config, let the pin settle, read the matching status word
  task automatic alt_case(input logic [7:0] o, input logic [5:0] c, input logic [6:0] e);
    apb(1'b1, o, {26'h0, c});
    repeat (3) @(posedge pclk);
    apb(1'b0, o + 8'h08, 32'h0);
    `CHK(rd[6:0], e)
  endtask
  // every role of the alternative pin on channel a, carrier detect only on channel b
  task automatic t_alt_roles();
    alt_case(8'h00, 6'h00, 7'h03);
    alt_case(8'h00, 6'h20, 7'h05);
    alt_case(8'h00, 6'h01, 7'h09);
    alt_case(8'h00, 6'h05, 7'h11);
    alt_case(8'h00, 6'h04, 7'h20);
    alt_case(8'h00, 6'h06, 7'h20);
    alt_case(8'h00, 6'h07, 7'h20);
    alt_case(8'h04, 6'h04, 7'h03);
    alt_case(8'h00, 6'h10, 7'h43);
    alt_b <= 1'b0;
    alt_case(8'h04, 6'h00, 7'h00);
    $display("t_alt_roles done");
  endtask
  // all modes with all source and direction settings
  task automatic t_tx_modes();
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, 8'h00, i);
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      `CHK(transmit_clock_pin_oe_a, i[4])
    end
    $display("t_tx_modes done");
  endtask
  // write a channel b config and let the pin flops follow it
  task automatic b_cfg(input logic [5:0] c);
    apb(1'b1, 8'h04, {26'h0, c});
    repeat (3) @(posedge pclk);
  endtask
  // channel b outputs against the far side levels the flops saw one edge back
  task automatic t_chan_b();
    b_cfg(6'h00);
    repeat (18) begin
      @(negedge pclk);
      `CHK({transmit_clock_pin_oe_b, transmit_clock_pin_out_b, tx_strobe_b}, 3'h0)
      `CHK({tx_clk_b, rx_clk_b}, pb_q[1:0])
    end
    b_cfg(6'h01);
    repeat (18) begin
      @(negedge pclk);
      `CHK({tx_strobe_b, tx_clk_b, rx_clk_b}, {pb_q[1], pb_q[0], pb_q[0]})
    end
    b_cfg(6'h13);
    repeat (18) begin
      @(negedge pclk);
      `CHK({transmit_clock_pin_oe_b, transmit_clock_pin_out_b, baud_in_b},
        {1'b1, pb_q[3], pb_q[0]})
    end
    b_cfg(6'h14);
    repeat (18) begin
      @(negedge pclk);
      `CHK({transmit_clock_pin_oe_b, transmit_clock_pin_out_b}, {1'b1, pb_q[5]})
    end
    b_cfg(6'h15);
    repeat (18) begin
      @(negedge pclk);
      `CHK({transmit_clock_pin_out_b, tx_clk_b}, {pb_q[4], pb_q[0]})
    end
    b_cfg(6'h1E);
    repeat (18) begin
      @(negedge pclk);
      `CHK({transmit_clock_pin_out_b, tx_clk_b}, {pb_q[2], pb_q[2]})
    end
    $display("t_chan_b done");
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_alt_roles();
    t_tx_modes();
    t_chan_b();
    give_verdict();
  end
  // the whole run needs well under a thousand cycles; this cuts a hang at 20000
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end
endmodule
